// ---- rtl/tpm_pin_mux.sv ----
// pin multiplexer for port b bit 4 and port a bits 0 to 3
// assumes control inputs are static relative to CORE_CLK; pins are
// synchronous; outputs are registered, one cycle after their cause
`timescale 1ns/1ns
module tpm_pin_mux (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CLK_EN,
    input  wire logic [7:0]  TIMER2_REMAP_OPTION,
    input  wire logic [3:0]  TIMER2_CAPTURE_COMPARE_ENABLE,
    input  wire logic [3:0]  TIMER2_CHANNEL_OUT,
    input  wire logic [3:0]  PORT_B_HIGH_CONFIG,
    input  wire logic [15:0] PORT_A_LOW_CONFIG,
    input  wire logic [1:0]  SERIAL1_MODE_SELECT,
    input  wire logic [7:0]  SERIAL1_UART_CONFIG,
    input  wire logic [7:0]  SERIAL1_SPI_CONFIG,
    input  wire logic [1:0]  SERIAL2_MODE_SELECT,
    input  wire logic [7:0]  SERIAL2_SPI_CONFIG,
    input  wire logic        SERIAL1_REQUEST_TO_SEND,
    input  wire logic        SERIAL2_MASTER_OUT,
    input  wire logic        SERIAL2_SLAVE_DATA_OUT,
    input  wire logic        SERIAL2_SPI_CLOCK_OUT,
    input  wire logic        SERIAL2_TWOWIRE_DATA_OUT,
    input  wire logic        SERIAL2_TWOWIRE_CLOCK_OUT,
    input  wire logic        TRACE_ENABLE,
    input  wire logic        PROCESSOR_TRACE_CLOCK,
    input  wire logic        PORT_B_BIT4_PIN_IN,
    input  wire logic        PORT_A_BIT0_PIN_IN,
    input  wire logic        PORT_A_BIT1_PIN_IN,
    input  wire logic        PORT_A_BIT2_PIN_IN,
    input  wire logic        PORT_A_BIT3_PIN_IN,
    output logic             PORT_B_BIT4_PIN_OUT,
    output logic             PORT_B_BIT4_PIN_OE,
    output logic             PORT_A_BIT0_PIN_OUT,
    output logic             PORT_A_BIT0_PIN_OE,
    output logic             PORT_A_BIT1_PIN_OUT,
    output logic             PORT_A_BIT1_PIN_OE,
    output logic             PORT_A_BIT2_PIN_OUT,
    output logic             PORT_A_BIT2_PIN_OE,
    output logic             PORT_A_BIT3_PIN_OUT,
    output logic             PORT_A_BIT3_PIN_OE,
    output logic             PORT_B_BIT1_TIMER_OUT,
    output logic             PORT_B_BIT1_TIMER_OE,
    output logic             PORT_B_BIT3_TIMER_OUT,
    output logic             PORT_B_BIT3_TIMER_OE,
    output logic [3:0]       TIMER2_CHANNEL_IN,
    output logic             SERIAL1_SLAVE_SELECT,
    output logic             SERIAL2_SLAVE_DATA_IN,
    output logic             SERIAL2_MASTER_IN,
    output logic             SERIAL2_TWOWIRE_DATA_IN,
    output logic             SERIAL2_TWOWIRE_CLOCK_IN,
    output logic             SERIAL2_SPI_CLOCK_IN,
    output logic             SERIAL2_SLAVE_SELECT
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // alternate push-pull output selected by a config field
    function automatic logic is_alt_out(input logic [3:0] field);
        is_alt_out = (field == tpm_pkg::CFG_ALT_OUT);
    endfunction : is_alt_out

    // alternate open-drain output selected by a config field
    function automatic logic is_alt_od(input logic [3:0] field);
        is_alt_od = (field == tpm_pkg::CFG_ALT_OD);
    endfunction : is_alt_od

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tpm_pkg::tpm_state_t state_ff;
    tpm_pkg::tpm_state_t nxt_state;

    logic [3:0] cfg_pb4;
    logic [3:0] cfg_pa0;
    logic [3:0] cfg_pa1;
    logic [3:0] cfg_pa2;
    logic [3:0] cfg_pa3;
    logic [3:0] remap;
    logic [3:0] tim_drive;
    logic       s1_uart;
    logic       s1_spi;
    logic       s2_spi;
    logic       s2_twi;
    logic       s1_slave;
    logic       s2_master;

    // config field extraction
    assign cfg_pb4 = PORT_B_HIGH_CONFIG[tpm_pkg::PB4_CFG_LSB +: 4];
    assign cfg_pa0 = PORT_A_LOW_CONFIG[tpm_pkg::PA0_CFG_LSB +: 4];
    assign cfg_pa1 = PORT_A_LOW_CONFIG[tpm_pkg::PA1_CFG_LSB +: 4];
    assign cfg_pa2 = PORT_A_LOW_CONFIG[tpm_pkg::PA2_CFG_LSB +: 4];
    assign cfg_pa3 = PORT_A_LOW_CONFIG[tpm_pkg::PA3_CFG_LSB +: 4];

    // remap bits per channel, index 0 is channel 1
    assign remap = {TIMER2_REMAP_OPTION[tpm_pkg::REMAP_CH4_BIT],
                    TIMER2_REMAP_OPTION[tpm_pkg::REMAP_CH3_BIT],
                    TIMER2_REMAP_OPTION[tpm_pkg::REMAP_CH2_BIT],
                    TIMER2_REMAP_OPTION[tpm_pkg::REMAP_CH1_BIT]};

    // channel output enabled in the capture-compare enable
    assign tim_drive = TIMER2_CAPTURE_COMPARE_ENABLE;

    // serial controller mode decode
    assign s1_uart   = (SERIAL1_MODE_SELECT == tpm_pkg::MODE_UART);
    assign s1_spi    = (SERIAL1_MODE_SELECT == tpm_pkg::MODE_SPI);
    assign s2_spi    = (SERIAL2_MODE_SELECT == tpm_pkg::MODE_SPI);
    assign s2_twi    = (SERIAL2_MODE_SELECT == tpm_pkg::MODE_TWI);
    assign s1_slave  = SERIAL1_SPI_CONFIG[tpm_pkg::SPI_MASTER_BIT] == 1'b0;
    assign s2_master = SERIAL2_SPI_CONFIG[tpm_pkg::SPI_MASTER_BIT];

    // ----------------------------------------------------------------
    // next-state: pin routing with timer priority
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        // port b bit 4: timer ch4 if remapped, else serial1 rts
        nxt_state.pb4 = '{out: 1'b0, oe: 1'b0};
        if (remap[3] && tim_drive[3] && is_alt_out(cfg_pb4)) begin
            nxt_state.pb4 = '{out: TIMER2_CHANNEL_OUT[3], oe: 1'b1};
        end else if (s1_uart && is_alt_out(cfg_pb4) &&
                     SERIAL1_UART_CONFIG[tpm_pkg::UART_HANDSHAKE_BIT]) begin
            nxt_state.pb4 = '{out: SERIAL1_REQUEST_TO_SEND, oe: 1'b1};
        end
        // port a bit 0: timer ch1 unless remapped, else serial2 mosi
        nxt_state.pa0 = '{out: 1'b0, oe: 1'b0};
        if (!remap[0] && tim_drive[0] && is_alt_out(cfg_pa0)) begin
            nxt_state.pa0 = '{out: TIMER2_CHANNEL_OUT[0], oe: 1'b1};
        end else if (s2_spi && s2_master && is_alt_out(cfg_pa0)) begin
            nxt_state.pa0 = '{out: SERIAL2_MASTER_OUT, oe: 1'b1};
        end
        // port a bit 1: timer ch3, twi data, or spi slave out
        nxt_state.pa1 = '{out: 1'b0, oe: 1'b0};
        if (!remap[2] && tim_drive[2] && is_alt_out(cfg_pa1)) begin
            nxt_state.pa1 = '{out: TIMER2_CHANNEL_OUT[2], oe: 1'b1};
        end else if (s2_twi && is_alt_od(cfg_pa1)) begin
            // open drain: enable only while pulling low
            nxt_state.pa1 = '{out: 1'b0, oe: !SERIAL2_TWOWIRE_DATA_OUT};
        end else if (s2_spi && !s2_master && is_alt_out(cfg_pa1)) begin
            nxt_state.pa1 = '{out: SERIAL2_SLAVE_DATA_OUT, oe: 1'b1};
        end
        // port a bit 2: timer ch4 unremapped, twi clock, spi clock
        nxt_state.pa2 = '{out: 1'b0, oe: 1'b0};
        if (!remap[3] && tim_drive[3] && is_alt_out(cfg_pa2)) begin
            nxt_state.pa2 = '{out: TIMER2_CHANNEL_OUT[3], oe: 1'b1};
        end else if (s2_twi && is_alt_od(cfg_pa2)) begin
            nxt_state.pa2 = '{out: 1'b0, oe: !SERIAL2_TWOWIRE_CLOCK_OUT};
        end else if (s2_spi && s2_master && is_alt_out(cfg_pa2)) begin
            nxt_state.pa2 = '{out: SERIAL2_SPI_CLOCK_OUT, oe: 1'b1};
        end
        // port a bit 3: timer ch2 unremapped, else trace clock
        nxt_state.pa3 = '{out: 1'b0, oe: 1'b0};
        if (!remap[1] && tim_drive[1] && is_alt_out(cfg_pa3)) begin
            nxt_state.pa3 = '{out: TIMER2_CHANNEL_OUT[1], oe: 1'b1};
        end else if (TRACE_ENABLE && is_alt_out(cfg_pa3)) begin
            nxt_state.pa3 = '{out: PROCESSOR_TRACE_CLOCK, oe: 1'b1};
        end
        // capture inputs follow the remap selection
        nxt_state.t2_ch1_in = remap[0] ? 1'b0 : PORT_A_BIT0_PIN_IN;
        nxt_state.t2_ch2_in = remap[1] ? 1'b0 : PORT_A_BIT3_PIN_IN;
        nxt_state.t2_ch3_in = remap[2] ? 1'b0 : PORT_A_BIT1_PIN_IN;
        nxt_state.t2_ch4_in = remap[3] ? PORT_B_BIT4_PIN_IN
                                       : PORT_A_BIT2_PIN_IN;
        // serial inputs when not routed: slave selects and twi lines idle high, spi data and clock inputs low
        nxt_state.s1_ssel_in = (s1_spi && s1_slave) ?
                               PORT_B_BIT4_PIN_IN : 1'b1;
        nxt_state.s2_mosi_in = (s2_spi && !s2_master) ?
                               PORT_A_BIT0_PIN_IN : 1'b0;
        nxt_state.s2_miso_in = (s2_spi && s2_master) ?
                               PORT_A_BIT1_PIN_IN : 1'b0;
        nxt_state.s2_sda_in  = s2_twi ? PORT_A_BIT1_PIN_IN : 1'b1;
        nxt_state.s2_scl_in  = s2_twi ? PORT_A_BIT2_PIN_IN : 1'b1;
        nxt_state.s2_sclk_in = (s2_spi && !s2_master) ?
                               PORT_A_BIT2_PIN_IN : 1'b0;
        nxt_state.s2_ssel_in = (s2_spi && !s2_master) ?
                               PORT_A_BIT3_PIN_IN : 1'b1;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_ff            <= '0;
            state_ff.s1_ssel_in <= 1'b1; // slave selects idle deasserted
            state_ff.s2_ssel_in <= 1'b1;
            state_ff.s2_sda_in  <= 1'b1;
            state_ff.s2_scl_in  <= 1'b1;
        end else if (CLK_EN) begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // remapped timer outputs on port b bits 1 and 3
    // ----------------------------------------------------------------
    logic pb1_out_ff;
    logic pb1_oe_ff;
    logic pb3_out_ff;
    logic pb3_oe_ff;

    // routed when the matching remap bit is set and channel enabled
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            pb1_out_ff <= 1'b0;
            pb1_oe_ff  <= 1'b0;
            pb3_out_ff <= 1'b0;
            pb3_oe_ff  <= 1'b0;
        end else if (CLK_EN) begin
            pb1_out_ff <= remap[0] & TIMER2_CHANNEL_OUT[0];
            pb1_oe_ff  <= remap[0] & tim_drive[0];
            pb3_out_ff <= remap[2] & TIMER2_CHANNEL_OUT[2];
            pb3_oe_ff  <= remap[2] & tim_drive[2];
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign PORT_B_BIT4_PIN_OUT      = state_ff.pb4.out;
    assign PORT_B_BIT4_PIN_OE       = state_ff.pb4.oe;
    assign PORT_A_BIT0_PIN_OUT      = state_ff.pa0.out;
    assign PORT_A_BIT0_PIN_OE       = state_ff.pa0.oe;
    assign PORT_A_BIT1_PIN_OUT      = state_ff.pa1.out;
    assign PORT_A_BIT1_PIN_OE       = state_ff.pa1.oe;
    assign PORT_A_BIT2_PIN_OUT      = state_ff.pa2.out;
    assign PORT_A_BIT2_PIN_OE       = state_ff.pa2.oe;
    assign PORT_A_BIT3_PIN_OUT      = state_ff.pa3.out;
    assign PORT_A_BIT3_PIN_OE       = state_ff.pa3.oe;
    assign PORT_B_BIT1_TIMER_OUT    = pb1_out_ff;
    assign PORT_B_BIT1_TIMER_OE     = pb1_oe_ff;
    assign PORT_B_BIT3_TIMER_OUT    = pb3_out_ff;
    assign PORT_B_BIT3_TIMER_OE     = pb3_oe_ff;
    assign TIMER2_CHANNEL_IN        = {state_ff.t2_ch4_in, state_ff.t2_ch3_in,
                                       state_ff.t2_ch2_in, state_ff.t2_ch1_in};
    assign SERIAL1_SLAVE_SELECT     = state_ff.s1_ssel_in;
    assign SERIAL2_SLAVE_DATA_IN    = state_ff.s2_mosi_in;
    assign SERIAL2_MASTER_IN        = state_ff.s2_miso_in;
    assign SERIAL2_TWOWIRE_DATA_IN  = state_ff.s2_sda_in;
    assign SERIAL2_TWOWIRE_CLOCK_IN = state_ff.s2_scl_in;
    assign SERIAL2_SPI_CLOCK_IN     = state_ff.s2_sclk_in;
    assign SERIAL2_SLAVE_SELECT     = state_ff.s2_ssel_in;

endmodule : tpm_pin_mux

// ---- rtl/tpm_pkg.sv ----
// constants and carrier types for the timer 2 / serial pin multiplexer
// assumes one core clock domain and a synchronous active-high reset
package tpm_pkg;

    // ----------------------------------------------------------------
    // remap option bit positions
    // ----------------------------------------------------------------
    localparam int REMAP_CH1_BIT = 4;
    localparam int REMAP_CH2_BIT = 5;
    localparam int REMAP_CH3_BIT = 6;
    localparam int REMAP_CH4_BIT = 7;

    // ----------------------------------------------------------------
    // config field positions and codes
    // ----------------------------------------------------------------
    localparam int UART_HANDSHAKE_BIT = 5;
    localparam int SPI_MASTER_BIT     = 4;
    localparam int CFG_FIELD_W        = 4;
    localparam int PB4_CFG_LSB        = 0;
    localparam int PA0_CFG_LSB        = 0;
    localparam int PA1_CFG_LSB        = 4;
    localparam int PA2_CFG_LSB        = 8;
    localparam int PA3_CFG_LSB        = 12;
    // alternate output and input codes of a port config field (arbitrary encoding)
    localparam logic [3:0] CFG_ALT_OUT    = 4'h9;
    localparam logic [3:0] CFG_ALT_OD     = 4'hd;
    localparam logic [3:0] CFG_INPUT      = 4'h4;

    // serial controller mode codes
    localparam logic [1:0] MODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_UART = 2'h1;
    localparam logic [1:0] MODE_SPI  = 2'h2;
    localparam logic [1:0] MODE_TWI  = 2'h3;

    // reset values of the registered pin outputs
    localparam logic [4:0] PIN_OUT_RST = 5'h00;
    localparam logic [4:0] PIN_OE_RST  = 5'h00;

    // one pin: output value and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } tpm_pin_t;

    // state of the multiplexer, except the port b bit 1 and 3 timer outputs
    typedef struct packed {
        tpm_pin_t pb4;
        tpm_pin_t pa0;
        tpm_pin_t pa1;
        tpm_pin_t pa2;
        tpm_pin_t pa3;
        logic     t2_ch1_in;
        logic     t2_ch2_in;
        logic     t2_ch3_in;
        logic     t2_ch4_in;
        logic     s1_ssel_in;
        logic     s2_mosi_in;
        logic     s2_miso_in;
        logic     s2_sda_in;
        logic     s2_scl_in;
        logic     s2_sclk_in;
        logic     s2_ssel_in;
    } tpm_state_t;

endpackage : tpm_pkg

// ---- testbench/tpm_board_model.sv ----
// board side of the five shared pins: a pattern when the pins float
// assumes pin order {pb4, pa3, pa2, pa1, pa0} and OE high = device drives
`timescale 1ns/1ns
module tpm_board_model (
    input  wire logic       CORE_CLK,
    input  wire logic [4:0] OUT,
    input  wire logic [4:0] OE,
    output logic      [4:0] LEVEL
);
    // ------------------------------------------------------------
    // board pattern, changes every cycle so no stale value is seen
    // ------------------------------------------------------------
    logic [4:0] pat_ff = 5'h15;
    always_ff @(posedge CORE_CLK) begin
        pat_ff <= {pat_ff[3:0], pat_ff[4] ^ pat_ff[2]};
    end
    // wire level: device wins where it drives
    assign LEVEL = (OE & OUT) | (~OE & pat_ff);
endmodule : tpm_board_model

// ---- testbench/tpm_pin_mux_props.sv ----
// assertions on the ports of the pin multiplexer
// assumes one clock, synchronous active-high reset, one-cycle latency
`timescale 1ns/1ns
module tpm_pin_mux_props (
    input wire logic        CORE_CLK, SYS_RST, CLK_EN,
    input wire logic [7:0]  TIMER2_REMAP_OPTION,
    input wire logic [3:0]  TIMER2_CAPTURE_COMPARE_ENABLE,
    input wire logic [3:0]  TIMER2_CHANNEL_OUT, PORT_B_HIGH_CONFIG,
    input wire logic [15:0] PORT_A_LOW_CONFIG,
    input wire logic [1:0]  SERIAL2_MODE_SELECT,
    input wire logic        SERIAL2_TWOWIRE_DATA_OUT,
    input wire logic        PORT_B_BIT4_PIN_IN, PORT_A_BIT0_PIN_IN,
    input wire logic        PORT_A_BIT2_PIN_IN,
    input wire logic        PORT_B_BIT4_PIN_OUT, PORT_B_BIT4_PIN_OE,
    input wire logic        PORT_A_BIT0_PIN_OE, PORT_A_BIT1_PIN_OUT,
    input wire logic        PORT_A_BIT1_PIN_OE, PORT_A_BIT3_PIN_OE,
    input wire logic        PORT_B_BIT1_TIMER_OE, PORT_B_BIT3_TIMER_OE,
    input wire logic [3:0]  TIMER2_CHANNEL_IN
);
    // reset seen at the last edge: the design was still clearing then
    logic rst_seen_ff;
    always_ff @(posedge CORE_CLK) begin
        rst_seen_ff <= SYS_RST;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST || rst_seen_ff);
    // ------------------------------------------------------------
    // routing relations, one cycle after cause
    // ------------------------------------------------------------
    AST_CH4_PB4: assert property (CLK_EN && TIMER2_REMAP_OPTION[7] &&
        TIMER2_CAPTURE_COMPARE_ENABLE[3] && PORT_B_HIGH_CONFIG == 4'h9
        |=> PORT_B_BIT4_PIN_OE && PORT_B_BIT4_PIN_OUT ==
        $past(TIMER2_CHANNEL_OUT[3])) else $error("ch4 not on pb4");
    AST_CH4_CAP: assert property (CLK_EN |=> TIMER2_CHANNEL_IN[3] ==
        ($past(TIMER2_REMAP_OPTION[7]) ? $past(PORT_B_BIT4_PIN_IN)
        : $past(PORT_A_BIT2_PIN_IN))) else $error("ch4 capture wrong");
    AST_CH1_OFF: assert property (CLK_EN && TIMER2_REMAP_OPTION[4] &&
        SERIAL2_MODE_SELECT != 2'h2 |=> !PORT_A_BIT0_PIN_OE)
        else $error("pa0 driven while remapped");
    AST_CH1_CAP: assert property (CLK_EN |=> TIMER2_CHANNEL_IN[0] ==
        (!$past(TIMER2_REMAP_OPTION[4]) && $past(PORT_A_BIT0_PIN_IN)))
        else $error("ch1 capture wrong");
    AST_PB1_OE: assert property (CLK_EN ##1 CLK_EN |->
        PORT_B_BIT1_TIMER_OE == ($past(TIMER2_REMAP_OPTION[4]) &&
        $past(TIMER2_CAPTURE_COMPARE_ENABLE[0]))) else $error("pb1 enable");
    AST_PB3_OE: assert property (CLK_EN |=> PORT_B_BIT3_TIMER_OE ==
        ($past(TIMER2_REMAP_OPTION[6]) &
        $past(TIMER2_CAPTURE_COMPARE_ENABLE[2]))) else $error("pb3 enable");
    AST_PA3_CFG: assert property (CLK_EN &&
        PORT_A_LOW_CONFIG[15:12] != 4'h9 |=> !PORT_A_BIT3_PIN_OE)
        else $error("pa3 driven without alternate output");
    AST_TWI_DATA: assert property (CLK_EN &&
        SERIAL2_MODE_SELECT == 2'h3 && PORT_A_LOW_CONFIG[7:4] == 4'hd
        |=> !PORT_A_BIT1_PIN_OUT && PORT_A_BIT1_PIN_OE ==
        !$past(SERIAL2_TWOWIRE_DATA_OUT)) else $error("twi data wrong");
    AST_HOLD: assert property (!CLK_EN |=> $stable(TIMER2_CHANNEL_IN)
        && $stable(PORT_A_BIT0_PIN_OE)) else $error("no hold");
endmodule : tpm_pin_mux_props

// ---- testbench/tpm_pin_mux_test.sv ----
// self-checking bench: random stimulus, reference model, cycle compare
// assumes the design, the board model and the checker are compiled first
`timescale 1ns/1ns
module tpm_pin_mux_test;
    logic CORE_CLK = 1'b0, SYS_RST = 1'b1, CLK_EN = 1'b1, TRACE_ENABLE;
    logic [7:0] TIMER2_REMAP_OPTION, SERIAL1_UART_CONFIG;
    logic [7:0] SERIAL1_SPI_CONFIG, SERIAL2_SPI_CONFIG;
    logic [3:0] TIMER2_CAPTURE_COMPARE_ENABLE, TIMER2_CHANNEL_OUT;
    logic [3:0] PORT_B_HIGH_CONFIG, TIMER2_CHANNEL_IN;
    logic [15:0] PORT_A_LOW_CONFIG;
    logic [1:0] SERIAL1_MODE_SELECT, SERIAL2_MODE_SELECT;
    logic SERIAL1_REQUEST_TO_SEND, SERIAL2_MASTER_OUT, PROCESSOR_TRACE_CLOCK;
    logic SERIAL2_SLAVE_DATA_OUT, SERIAL2_SPI_CLOCK_OUT;
    logic SERIAL2_TWOWIRE_DATA_OUT, SERIAL2_TWOWIRE_CLOCK_OUT;
    logic PORT_B_BIT4_PIN_IN, PORT_A_BIT0_PIN_IN, PORT_A_BIT1_PIN_IN;
    logic PORT_A_BIT2_PIN_IN, PORT_A_BIT3_PIN_IN;
    logic PORT_B_BIT4_PIN_OUT, PORT_B_BIT4_PIN_OE, PORT_A_BIT0_PIN_OUT;
    logic PORT_A_BIT0_PIN_OE, PORT_A_BIT1_PIN_OUT, PORT_A_BIT1_PIN_OE;
    logic PORT_A_BIT2_PIN_OUT, PORT_A_BIT2_PIN_OE, PORT_A_BIT3_PIN_OUT;
    logic PORT_A_BIT3_PIN_OE, PORT_B_BIT1_TIMER_OUT, PORT_B_BIT1_TIMER_OE;
    logic PORT_B_BIT3_TIMER_OUT, PORT_B_BIT3_TIMER_OE, SERIAL1_SLAVE_SELECT;
    logic SERIAL2_SLAVE_DATA_IN, SERIAL2_MASTER_IN, SERIAL2_TWOWIRE_DATA_IN;
    logic SERIAL2_TWOWIRE_CLOCK_IN, SERIAL2_SPI_CLOCK_IN;
    logic SERIAL2_SLAVE_SELECT, chk = 1'b0;
    logic [24:0] exp_v, got;
    int errors = 0, tests_run = 0;
    tpm_pin_mux dut_u (.*);
    tpm_board_model board_u (.CORE_CLK(CORE_CLK),
        .OUT({PORT_B_BIT4_PIN_OUT, PORT_A_BIT3_PIN_OUT, PORT_A_BIT2_PIN_OUT,
              PORT_A_BIT1_PIN_OUT, PORT_A_BIT0_PIN_OUT}),
        .OE({PORT_B_BIT4_PIN_OE, PORT_A_BIT3_PIN_OE, PORT_A_BIT2_PIN_OE,
             PORT_A_BIT1_PIN_OE, PORT_A_BIT0_PIN_OE}),
        .LEVEL({PORT_B_BIT4_PIN_IN, PORT_A_BIT3_PIN_IN, PORT_A_BIT2_PIN_IN,
                PORT_A_BIT1_PIN_IN, PORT_A_BIT0_PIN_IN}));
    initial begin
        forever #20 CORE_CLK = ~CORE_CLK;
    end
    // ------------------------------------------------------------
    // reference model: pins as {out, oe}, timer first in each chain
    // ------------------------------------------------------------
    function automatic logic [24:0] model();
        logic [7:0] r;
        logic [3:0] e, o;
        logic [15:0] a;
        logic sp, tw, m;
        logic [1:0] p4, p0, p1, p2, p3;
        r = TIMER2_REMAP_OPTION; e = TIMER2_CAPTURE_COMPARE_ENABLE;
        o = TIMER2_CHANNEL_OUT; a = PORT_A_LOW_CONFIG;
        sp = SERIAL2_MODE_SELECT == 2'h2; tw = SERIAL2_MODE_SELECT == 2'h3;
        m = SERIAL2_SPI_CONFIG[4];
        p4 = (r[7] & e[3] & PORT_B_HIGH_CONFIG == 4'h9) ? {o[3], 1'b1}
           : (SERIAL1_MODE_SELECT == 2'h1 & SERIAL1_UART_CONFIG[5] &
              PORT_B_HIGH_CONFIG == 4'h9) ? {SERIAL1_REQUEST_TO_SEND, 1'b1}
           : 2'h0;
        p0 = (!r[4] & e[0] & a[3:0] == 4'h9) ? {o[0], 1'b1}
           : (sp & m & a[3:0] == 4'h9) ? {SERIAL2_MASTER_OUT, 1'b1} : 2'h0;
        p1 = (!r[6] & e[2] & a[7:4] == 4'h9) ? {o[2], 1'b1}
           : (tw & a[7:4] == 4'hd) ? {1'b0, !SERIAL2_TWOWIRE_DATA_OUT}
           : (sp & !m & a[7:4] == 4'h9) ? {SERIAL2_SLAVE_DATA_OUT, 1'b1}
           : 2'h0;
        p2 = (!r[7] & e[3] & a[11:8] == 4'h9) ? {o[3], 1'b1}
           : (tw & a[11:8] == 4'hd) ? {1'b0, !SERIAL2_TWOWIRE_CLOCK_OUT}
           : (sp & m & a[11:8] == 4'h9) ? {SERIAL2_SPI_CLOCK_OUT, 1'b1}
           : 2'h0;
        p3 = (!r[5] & e[1] & a[15:12] == 4'h9) ? {o[1], 1'b1}
           : (TRACE_ENABLE & a[15:12] == 4'h9)
           ? {PROCESSOR_TRACE_CLOCK, 1'b1} : 2'h0;
        return {p4, p0, p1, p2, p3, r[4] & o[0], r[4] & e[0],
            r[6] & o[2], r[6] & e[2],
            r[7] ? PORT_B_BIT4_PIN_IN : PORT_A_BIT2_PIN_IN,
            !r[6] & PORT_A_BIT1_PIN_IN, !r[5] & PORT_A_BIT3_PIN_IN,
            !r[4] & PORT_A_BIT0_PIN_IN,
            (SERIAL1_MODE_SELECT == 2'h2 & !SERIAL1_SPI_CONFIG[4])
                ? PORT_B_BIT4_PIN_IN : 1'b1,
            sp & !m & PORT_A_BIT0_PIN_IN, sp & m & PORT_A_BIT1_PIN_IN,
            tw ? PORT_A_BIT1_PIN_IN : 1'b1, tw ? PORT_A_BIT2_PIN_IN : 1'b1,
            sp & !m & PORT_A_BIT2_PIN_IN,
            (sp & !m) ? PORT_A_BIT3_PIN_IN : 1'b1};
    endfunction : model
    always @(posedge CORE_CLK) begin
        if (SYS_RST) exp_v = 25'h000004d;
        else if (CLK_EN) exp_v = model();
    end
    // compare settled outputs; pin values only matter while driven
    always @(negedge CORE_CLK) begin
        got = {PORT_B_BIT4_PIN_OUT, PORT_B_BIT4_PIN_OE, PORT_A_BIT0_PIN_OUT,
            PORT_A_BIT0_PIN_OE, PORT_A_BIT1_PIN_OUT, PORT_A_BIT1_PIN_OE,
            PORT_A_BIT2_PIN_OUT, PORT_A_BIT2_PIN_OE, PORT_A_BIT3_PIN_OUT,
            PORT_A_BIT3_PIN_OE, PORT_B_BIT1_TIMER_OUT, PORT_B_BIT1_TIMER_OE,
            PORT_B_BIT3_TIMER_OUT, PORT_B_BIT3_TIMER_OE, TIMER2_CHANNEL_IN,
            SERIAL1_SLAVE_SELECT, SERIAL2_SLAVE_DATA_IN, SERIAL2_MASTER_IN,
            SERIAL2_TWOWIRE_DATA_IN, SERIAL2_TWOWIRE_CLOCK_IN,
            SERIAL2_SPI_CLOCK_IN, SERIAL2_SLAVE_SELECT};
        for (int i = 0; i < 7; i++) begin
            if (!exp_v[23 - 2 * i]) got[24 - 2 * i] = exp_v[24 - 2 * i];
        end
        if (chk) begin
            tests_run++;
            if (got !== exp_v) begin
                errors++;
                $display("wrong value t=%0t got=%h exp=%h", $time, got, exp_v);
            end
        end
    end
    // config field: mostly one of the meaningful codes
    function automatic logic [3:0] pick();
        logic [3:0] c[4] = '{4'h9, 4'hd, 4'h4, 4'h0};
        return c[$urandom % 4] ^ (($urandom % 5 == 0) ? 4'($urandom) : 4'h0);
    endfunction : pick
    task automatic run(input int n, input bit en_rand, input string nm);
        repeat (n) begin
            @(posedge CORE_CLK);
            {TIMER2_REMAP_OPTION, SERIAL1_UART_CONFIG} <= 16'($urandom);
            {SERIAL1_SPI_CONFIG, SERIAL2_SPI_CONFIG} <= 16'($urandom);
            {TIMER2_CAPTURE_COMPARE_ENABLE, TIMER2_CHANNEL_OUT} <= 8'($urandom);
            {SERIAL1_MODE_SELECT, SERIAL2_MODE_SELECT} <= 4'($urandom);
            {SERIAL1_REQUEST_TO_SEND, SERIAL2_MASTER_OUT, TRACE_ENABLE,
             SERIAL2_SLAVE_DATA_OUT, SERIAL2_SPI_CLOCK_OUT,
             SERIAL2_TWOWIRE_DATA_OUT, SERIAL2_TWOWIRE_CLOCK_OUT,
             PROCESSOR_TRACE_CLOCK} <= 8'($urandom);
            PORT_B_HIGH_CONFIG <= pick();
            PORT_A_LOW_CONFIG <= {pick(), pick(), pick(), pick()};
            CLK_EN <= en_rand ? ($urandom % 6 != 0) : 1'b0;
        end
        $display("test %s done, errors %0d", nm, errors);
    endtask : run
    task automatic final_report();
        $display("comparisons %0d, errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(59761));
        run(8, 1'b1, "reset");
        SYS_RST <= 1'b0;
        chk <= 1'b1;
        run(3000, 1'b1, "random_routing");
        SYS_RST <= 1'b1;
        run(3, 1'b1, "mid_reset");
        SYS_RST <= 1'b0;
        run(30, 1'b0, "clock_enable_hold");
        run(1000, 1'b1, "random_after");
        final_report();
    end
    initial begin
        repeat (6000) @(posedge CORE_CLK);
        errors++;
        final_report();
    end
endmodule : tpm_pin_mux_test
bind tpm_pin_mux tpm_pin_mux_props props_u (.*);
